// *** hdl/aftf_pkg.sv ***
// Shared constants for the host controller of a 64-word fall-through FIFO.
package aftf_pkg;

    // Word width of the wide variant; the narrow variant uses the low 4 bits.
    localparam int WORD_W = 5;
    // Depth of the store outside; used by the store model and the bench, not by the status logic.
    localparam int FIFO_DEPTH = 64;
    // Entries in the local output buffer.
    localparam int BUF_DEPTH = 2;

    // Clock period of ref_clk in nanoseconds (40 MHz).
    localparam int CLK_PERIOD_NS = 25;

    // Pin timing of the store, in nanoseconds or microseconds.
    localparam int CLR_PULSE_NS = 35; // Least clear pulse width.
    localparam int CLR_GAP_NS = 35; // Least gap from clear to load.
    localparam int SI_LOW_NS = 35; // Least load strobe low time.
    localparam int RDY_LOW_NS = 45; // Longest load rise to ready low.
    localparam int SO_LOW_NS = 35; // Least unload strobe low time.
    localparam int VAL_LOW_NS = 55; // Longest unload rise to valid low.
    localparam int PT_US = 3;          // Longest fall-through time.

    // Round a least time up to whole cycles, never below one.
    function automatic int ns_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_up

    // Counter width used by every timer of the controller.
    localparam int CNT_W = 8;
    typedef logic [CNT_W-1:0] aftf_cnt_t;
    typedef logic [WORD_W-1:0] aftf_word_t;

    // Cycle counts derived from the times above.
    localparam aftf_cnt_t CLR_LOW_CYC = aftf_cnt_t'(ns_up(CLR_PULSE_NS));
    localparam aftf_cnt_t CLR_GAP_CYC = aftf_cnt_t'(ns_up(CLR_GAP_NS));
    localparam aftf_cnt_t CLR_TOTAL_CYC = aftf_cnt_t'(ns_up(CLR_PULSE_NS)
                                          + ns_up(CLR_GAP_NS));
    // The strobe stays high until the ready flag is surely low.
    localparam aftf_cnt_t SI_HIGH_CYC = aftf_cnt_t'(ns_up(RDY_LOW_NS));
    localparam aftf_cnt_t SI_LOW_CYC = aftf_cnt_t'(ns_up(SI_LOW_NS));
    localparam aftf_cnt_t SO_HIGH_CYC = aftf_cnt_t'(ns_up(VAL_LOW_NS));
    localparam aftf_cnt_t SO_LOW_CYC = aftf_cnt_t'(ns_up(SO_LOW_NS));
    // A longest time rounds down.
    localparam aftf_cnt_t PT_CYC = aftf_cnt_t'(PT_US * 1000 / CLK_PERIOD_NS);

    // Reset values of the pins driven toward the store.
    localparam logic CLR_N_RST = 1'h0;
    localparam aftf_word_t WORD_RST = aftf_word_t'(0);

endpackage : aftf_pkg

// *** hdl/aftf_stream_if.sv ***
`timescale 1ns/100ps
// Valid/ready word stream between the controller and its buffer.
interface aftf_stream_if;
    import aftf_pkg::*;
    logic valid;          // Source offers a word.
    logic ready;          // Sink can take a word.
    aftf_word_t data;     // The word offered.
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : aftf_stream_if

// *** hdl/aftf_pair_buf.sv ***
`timescale 1ns/100ps
// Two-entry buffer; entry 0 is always the head, so the output is a flop.
module aftf_pair_buf
    import aftf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    aftf_stream_if.snk push,
    aftf_stream_if.src pop
);

    aftf_word_t mem_ff [BUF_DEPTH];      // Storage, head at index 0.
    aftf_word_t nxt_mem [BUF_DEPTH];
    logic [1:0] cnt_ff;                  // Words held.
    logic [1:0] nxt_cnt;
    logic in_ready_ff;                   // Room for one more word.
    logic nxt_in_ready;
    logic out_valid_ff;                  // Head holds a word.
    logic nxt_out_valid;
    logic do_push;
    logic do_pop;
    logic [1:0] base;

    assign do_push = push.valid && in_ready_ff;
    assign do_pop = out_valid_ff && pop.ready;

    // Shift on a pop, then place a pushed word behind the survivors.
    always_comb begin
        base = cnt_ff - {1'h0, do_pop};
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (do_pop) begin
                // Shifting keeps arrival order at the head.
                nxt_mem[i] = (i + 1 < BUF_DEPTH)
                             ? mem_ff[(i + 1) % BUF_DEPTH] : mem_ff[i];
            end else begin
                nxt_mem[i] = mem_ff[i];
            end
            if (do_push && (base == 2'(i))) begin
                nxt_mem[i] = push.data;
            end
        end
        nxt_cnt = base + {1'h0, do_push};
        nxt_in_ready = (nxt_cnt != 2'h2);
        nxt_out_valid = (nxt_cnt != 2'h0);
    end

    // Registers only.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < BUF_DEPTH; i++) begin
                mem_ff[i] <= WORD_RST;
            end
            cnt_ff <= 2'h0;
            in_ready_ff <= 1'h1;
            out_valid_ff <= 1'h0;
        end else begin
            mem_ff <= nxt_mem;
            cnt_ff <= nxt_cnt;
            in_ready_ff <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
        end
    end

    assign push.ready = in_ready_ff;
    assign pop.valid = out_valid_ff;
    assign pop.data = mem_ff[0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // The count never passes the depth.
    AST_BUF_BOUND: assert property (cnt_ff <= 2'h2)
        else $error("buffer count above two");
    // A pop from a full buffer with no push brings the second word up.
    AST_BUF_ORDER: assert property (
        (do_pop && !do_push && cnt_ff == 2'h2)
        |=> (mem_ff[0] == $past(mem_ff[1])))
        else $error("buffer lost word order");

endmodule : aftf_pair_buf

// *** hdl/aftf_host.sv ***
`timescale 1ns/100ps
module aftf_host
    import aftf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clr_req,
    input wire logic wr_valid,
    input wire aftf_word_t wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output aftf_word_t rd_data,
    input wire logic rd_ready,
    output logic fifo_full,
    output logic fifo_empty,
    output logic fifo_clear_n,
    output logic load_strobe,
    output aftf_word_t write_word,
    input wire logic accept_ready,
    output logic unload_strobe,
    input wire aftf_word_t read_word,
    input wire logic output_valid
);

    typedef enum {W_IDLE, W_SETUP, W_HIGH, W_LOW, W_WAIT} aftf_wst_t;
    typedef enum {R_IDLE, R_HIGH, R_LOW} aftf_rst_t;

    // Saturating increment shared by the two status timers.
    function automatic aftf_cnt_t sat_inc(input aftf_cnt_t v);
        return (v == PT_CYC) ? v : v + aftf_cnt_t'(1);
    endfunction : sat_inc

    // Clear sequencer.
    aftf_cnt_t clr_cnt_ff;     // Cycles left of pulse plus settle gap.
    aftf_cnt_t nxt_clr_cnt;
    logic clr_n_ff;            // Clear pin, low asserts.
    logic nxt_clr_n;
    logic clr_busy;

    assign clr_busy = (clr_cnt_ff != aftf_cnt_t'(0));

    // Reset itself starts a full clear, so the store is always emptied first.
    always_comb begin
        if (clr_req) begin
            nxt_clr_cnt = CLR_TOTAL_CYC;
        end else if (clr_busy) begin
            nxt_clr_cnt = clr_cnt_ff - aftf_cnt_t'(1);
        end else begin
            nxt_clr_cnt = clr_cnt_ff;
        end
        nxt_clr_n = !(nxt_clr_cnt > CLR_GAP_CYC);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt_ff <= CLR_TOTAL_CYC;
            clr_n_ff <= CLR_N_RST;
        end else begin
            clr_cnt_ff <= nxt_clr_cnt;
            clr_n_ff <= nxt_clr_n;
        end
    end

    // Load side.
    aftf_wst_t wst_ff;
    aftf_wst_t nxt_wst;
    aftf_cnt_t wcnt_ff;        // Phase timer of the load strobe.
    aftf_cnt_t nxt_wcnt;
    logic load_ff;
    logic nxt_load;
    aftf_word_t wword_ff;      // Word on the store's inputs.
    aftf_word_t nxt_wword;
    logic wr_ready_ff;
    logic nxt_wr_ready;
    logic wr_take;

    // The ready flag is checked again at the handshake, since it is a pin.
    assign wr_take = wr_valid && wr_ready_ff && accept_ready;

    // One word per strobe; the word is set a cycle before the rise.
    always_comb begin
        nxt_wst = wst_ff;
        nxt_wcnt = wcnt_ff;
        nxt_load = 1'h0;
        nxt_wword = wword_ff;
        case (wst_ff)
            W_IDLE: begin
                if (wr_take && !clr_busy) begin
                    nxt_wword = wr_data;
                    nxt_wst = W_SETUP;
                end
            end
            W_SETUP: begin
                // Rise comes now; the word has had one cycle of setup.
                nxt_load = 1'h1;
                nxt_wcnt = SI_HIGH_CYC - aftf_cnt_t'(1);
                nxt_wst = W_HIGH;
            end
            W_HIGH: begin
                // Held until ready is surely low, which also covers hold.
                if (wcnt_ff != aftf_cnt_t'(0)) begin
                    nxt_load = 1'h1;
                    nxt_wcnt = wcnt_ff - aftf_cnt_t'(1);
                end else begin
                    nxt_wcnt = SI_LOW_CYC - aftf_cnt_t'(1);
                    nxt_wst = W_LOW;
                end
            end
            W_LOW: begin
                if (wcnt_ff != aftf_cnt_t'(0)) begin
                    nxt_wcnt = wcnt_ff - aftf_cnt_t'(1);
                end else begin
                    nxt_wst = W_WAIT;
                end
            end
            W_WAIT: begin
                // A full store keeps ready low; nothing is sent meanwhile.
                if (accept_ready) begin
                    nxt_wst = W_IDLE;
                end
            end
            default: begin
                nxt_wst = W_IDLE;
            end
        endcase
        if (clr_busy || clr_req) begin
            // Clearing empties the store, so a half-done load is dropped.
            nxt_wst = W_IDLE;
            nxt_load = 1'h0;
        end
        nxt_wr_ready = (nxt_wst == W_IDLE) && !clr_req && !clr_busy
                       && (nxt_clr_cnt == aftf_cnt_t'(0)) && accept_ready;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wst_ff <= W_IDLE;
            wcnt_ff <= aftf_cnt_t'(0);
            load_ff <= 1'h0;
            wword_ff <= WORD_RST;
            wr_ready_ff <= 1'h0;
        end else begin
            wst_ff <= nxt_wst;
            wcnt_ff <= nxt_wcnt;
            load_ff <= nxt_load;
            wword_ff <= nxt_wword;
            wr_ready_ff <= nxt_wr_ready;
        end
    end

    // Unload side.
    aftf_stream_if push_if ();
    aftf_stream_if pop_if ();

    aftf_rst_t rst_ff;
    aftf_rst_t nxt_rst;
    aftf_cnt_t rcnt_ff;        // Phase timer of the unload strobe.
    aftf_cnt_t nxt_rcnt;
    logic unload_ff;
    logic nxt_unload;
    logic push_valid_ff;       // One-cycle push into the buffer.
    logic nxt_push_valid;
    aftf_word_t push_data_ff;
    aftf_word_t nxt_push_data;

    // The word is taken at the rise, while it is still known valid.
    always_comb begin
        nxt_rst = rst_ff;
        nxt_rcnt = rcnt_ff;
        nxt_unload = 1'h0;
        nxt_push_valid = 1'h0;
        nxt_push_data = push_data_ff;
        case (rst_ff)
            R_IDLE: begin
                // A full buffer stalls unloading, so no word is lost.
                if (output_valid && push_if.ready && !clr_busy) begin
                    nxt_unload = 1'h1;
                    nxt_push_valid = 1'h1;
                    nxt_push_data = read_word;
                    nxt_rcnt = SO_HIGH_CYC - aftf_cnt_t'(1);
                    nxt_rst = R_HIGH;
                end
            end
            R_HIGH: begin
                // Held until valid has surely dropped.
                if (rcnt_ff != aftf_cnt_t'(0)) begin
                    nxt_unload = 1'h1;
                    nxt_rcnt = rcnt_ff - aftf_cnt_t'(1);
                end else begin
                    nxt_rcnt = SO_LOW_CYC - aftf_cnt_t'(1);
                    nxt_rst = R_LOW;
                end
            end
            R_LOW: begin
                if (rcnt_ff != aftf_cnt_t'(0)) begin
                    nxt_rcnt = rcnt_ff - aftf_cnt_t'(1);
                end else begin
                    nxt_rst = R_IDLE;
                end
            end
            default: begin
                nxt_rst = R_IDLE;
            end
        endcase
        if (clr_busy || clr_req) begin
            nxt_rst = R_IDLE;
            nxt_unload = 1'h0;
            nxt_push_valid = 1'h0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_ff <= R_IDLE;
            rcnt_ff <= aftf_cnt_t'(0);
            unload_ff <= 1'h0;
            push_valid_ff <= 1'h0;
            push_data_ff <= WORD_RST;
        end else begin
            rst_ff <= nxt_rst;
            rcnt_ff <= nxt_rcnt;
            unload_ff <= nxt_unload;
            push_valid_ff <= nxt_push_valid;
            push_data_ff <= nxt_push_data;
        end
    end

    assign push_if.valid = push_valid_ff;
    assign push_if.data = push_data_ff;
    assign pop_if.ready = rd_ready;

    aftf_pair_buf u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .push(push_if),
        .pop(pop_if)
    );

    // Full and empty status.
    // Index 0 watches ready for full, index 1 watches valid for empty.
    logic [1:0] watch;
    logic [1:0] stat_ff;
    assign watch = {output_valid, accept_ready};

    // A flag only rises after a whole fall-through time of low level.
    generate
        for (genvar g = 0; g < 2; g++) begin : g_stat
            aftf_cnt_t low_cnt_ff;
            aftf_cnt_t nxt_low_cnt;
            logic nxt_stat;
            always_comb begin
                nxt_low_cnt = watch[g] ? aftf_cnt_t'(0)
                                       : sat_inc(low_cnt_ff);
                nxt_stat = (nxt_low_cnt == PT_CYC);
            end
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    low_cnt_ff <= aftf_cnt_t'(0);
                    stat_ff[g] <= 1'h0;
                end else begin
                    low_cnt_ff <= nxt_low_cnt;
                    stat_ff[g] <= nxt_stat;
                end
            end
        end
    endgenerate

    assign fifo_full = stat_ff[0];
    assign fifo_empty = stat_ff[1];
    assign fifo_clear_n = clr_n_ff;
    assign load_strobe = load_ff;
    assign write_word = wword_ff;
    assign unload_strobe = unload_ff;
    assign wr_ready = wr_ready_ff;
    assign rd_valid = pop_if.valid;
    assign rd_data = pop_if.data;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence si_rise;
        $rose(load_ff);
    endsequence
    sequence so_rise;
        $rose(unload_ff);
    endsequence

    AST_CLR_WIDTH: assert property (
        $fell(clr_n_ff) |-> !clr_n_ff [*2])
        else $error("clear pulse too short");
    AST_CLR_QUIET: assert property (
        !clr_n_ff |-> !load_ff && !unload_ff)
        else $error("strobe during clear");
    AST_LOAD_READY: assert property (
        si_rise |-> $past(accept_ready, 2))
        else $error("load started without ready");
    AST_SI_SHAPE: assert property (
        si_rise |-> load_ff [*2] ##1 !load_ff [*2])
        else $error("load strobe shape wrong");
    AST_SI_GAP: assert property (si_rise |=> !$rose(load_ff) [*3])
        else $error("loads too close");
    // The word changes one edge before the rise, then holds past the fall.
    AST_WORD_HOLD: assert property (
        si_rise |=> $stable(wword_ff) [*2])
        else $error("word moved around load");
    AST_UNLOAD_VALID: assert property (
        so_rise |-> $past(output_valid))
        else $error("unload without valid");
    AST_SO_SHAPE: assert property (
        so_rise |-> unload_ff [*3] ##1 !unload_ff [*2])
        else $error("unload strobe shape wrong");
    AST_SO_GAP: assert property (so_rise |=> !$rose(unload_ff) [*4])
        else $error("unloads too close");
    AST_PUSH_WORD: assert property (
        so_rise |-> push_valid_ff && push_data_ff == $past(read_word))
        else $error("unloaded word not pushed");
    AST_FULL_CAUSE: assert property (
        $rose(stat_ff[0]) |-> !$past(accept_ready))
        else $error("full without ready low");

endmodule : aftf_host

// *** tb/aftf_store_model.sv ***
`timescale 1ns/100ps
// Pin-level model of the 64-word fall-through store. It moves on ref_clk
// edges, which is coarser than the real part, so the controller sees it
// as a synchronous partner; slow stretches the fall-through delay.
module aftf_store_model
    import aftf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic fifo_clear_n,
    input wire logic load_strobe,
    input wire aftf_word_t write_word,
    output logic accept_ready,
    input wire logic unload_strobe,
    output aftf_word_t read_word,
    output logic output_valid
);
    localparam int FAST_CYC = 1; // Prompt fall-through, in cycles.
    localparam int SLOW_CYC = 60; // Slow fall-through, half the longest.
    aftf_word_t store_q[$]; // Words held, oldest first.
    logic load_ff, unload_ff; // Strobes seen at the previous edge.
    int fall_cnt; // Cycles the head word has been falling.

    // Flags start low; nothing is usable before the first clear.
    initial begin
        accept_ready = 1'h0;
        output_valid = 1'h0;
        read_word = 5'h00;
        load_ff = 1'h0;
        unload_ff = 1'h0;
        fall_cnt = 0;
    end

    // Clear, load, unload and fall-through, one edge at a time.
    always @(posedge ref_clk) begin
        load_ff <= load_strobe;
        unload_ff <= unload_strobe;
        if (fifo_clear_n !== 1'h1) begin
            // Clear marks every cell empty and opens the input.
            store_q.delete();
            accept_ready <= 1'h1;
            output_valid <= 1'h0;
            fall_cnt <= 0;
        end else begin
            // A load into a full store is dropped, contents unchanged.
            if (load_strobe && !load_ff
                && store_q.size() < FIFO_DEPTH) begin
                store_q.push_back(write_word);
            end
            // Busy while the strobe is high, then ready only with space.
            accept_ready <= !load_strobe
                && store_q.size() < FIFO_DEPTH;
            if (unload_strobe && !unload_ff && output_valid) begin
                // The head leaves; read_word keeps showing it meanwhile.
                void'(store_q.pop_front());
                output_valid <= 1'h0;
                fall_cnt <= 0;
            end else if (!unload_strobe && !output_valid
                         && store_q.size() > 0) begin
                // The next word reaches the output after the delay.
                if (fall_cnt >= (slow ? SLOW_CYC : FAST_CYC)) begin
                    read_word <= store_q[0];
                    output_valid <= 1'h1;
                end else begin
                    fall_cnt <= fall_cnt + 1;
                end
            end
        end
    end
endmodule : aftf_store_model

// *** tb/aftf_host_tb.sv ***
`timescale 1ns/100ps
// Bench: the controller drives the store model, the bench plays the user.
module aftf_host_tb
    import aftf_pkg::*;
;
    logic ref_clk, rst_n, clr_req, wr_valid, wr_ready, rd_valid, rd_ready;
    logic fifo_full, fifo_empty, fifo_clear_n, load_strobe, unload_strobe;
    logic accept_ready, output_valid, slow; // Store pins and model mode.
    aftf_word_t wr_data, rd_data, write_word, read_word; // Word buses.
    int err_total, comparisons; // Mismatch and comparison counts.
    int ld_gap, ul_gap; // Negedges since the last strobe rise.
    logic ld_seen, ul_seen; // Strobe levels at the previous negedge.

    aftf_host dut (.ref_clk, .rst_n, .clr_req, .wr_valid, .wr_data,
        .wr_ready, .rd_valid, .rd_data, .rd_ready, .fifo_full, .fifo_empty,
        .fifo_clear_n, .load_strobe, .write_word, .accept_ready,
        .unload_strobe, .read_word, .output_valid);
    aftf_store_model store (.ref_clk, .slow, .fifo_clear_n, .load_strobe,
        .write_word, .accept_ready, .unload_strobe, .read_word,
        .output_valid);

    // Free-running 40 MHz clock.
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Compare one value; a mismatch is reported at once and counted.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%0h expected=%0h", $time,
                seen, exp);
        end
    endtask : check

    // Print the counts and the verdict, then end the run.
    task automatic stop_test();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    // Test word for index i; a stride of 7 walks all 32 codes.
    function automatic aftf_word_t pat(input int i);
        return aftf_word_t'(i * 7 + 3);
    endfunction : pat

    // Offer a word until taken or lim cycles pass; wr_valid stays high so
    // a following call never toggles it within one time step.
    task automatic wr_word(input aftf_word_t w, input int lim, output bit ok);
        int n;
        n = 0;
        wr_valid = 1'h1;
        wr_data = w;
        while (!(wr_ready === 1'h1 && accept_ready === 1'h1) && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        ok = (wr_ready === 1'h1 && accept_ready === 1'h1);
        @(negedge ref_clk);
    endtask : wr_word

    // Take the head word and compare it with the expected one.
    task automatic rd_word(input aftf_word_t exp);
        int n;
        n = 0;
        rd_ready = 1'h1;
        while (rd_valid !== 1'h1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check(32'(rd_data), 32'(exp));
        @(negedge ref_clk);
    endtask : rd_word

    // Strobes must be spaced and must only meet a raised ready flag (load) or valid flag (unload).
    always @(negedge ref_clk) begin
        if (rst_n === 1'h1 && load_strobe === 1'h1 && ld_seen !== 1'h1) begin
            check(32'(ld_gap >= 4), 32'h1);
            check(32'(accept_ready), 32'h1);
            ld_gap = 0;
        end else if (ld_gap < 1000) begin
            ld_gap++;
        end
        if (rst_n === 1'h1 && unload_strobe === 1'h1 && ul_seen !== 1'h1) begin
            check(32'(ul_gap >= 4), 32'h1);
            check(32'(output_valid), 32'h1);
            ul_gap = 0;
        end else if (ul_gap < 1000) begin
            ul_gap++;
        end
        ld_seen = load_strobe;
        ul_seen = unload_strobe;
    end

    // Reset holds the clear pin low; release must leave an empty store.
    task automatic t_reset();
        int n;
        check(32'(fifo_clear_n), 32'h0);
        rst_n = 1'h1;
        for (n = 0; n < 20 && wr_ready !== 1'h1; n++) @(negedge ref_clk);
        check(32'(wr_ready & accept_ready), 32'h1);
        check(32'(output_valid), 32'h0);
    endtask : t_reset

    // Writer and reader run at once, so words flow back to back.
    task automatic t_stream();
        bit ok;
        fork
            begin
                // Drop the offer at once, or the last word is loaded twice.
                for (int i = 0; i < 8; i++) wr_word(pat(100 + i), 200, ok);
                wr_valid = 1'h0;
            end
            for (int j = 0; j < 8; j++) rd_word(pat(100 + j));
        join
        rd_ready = 1'h0;
        @(negedge ref_clk);
    endtask : t_stream

    // Fill store and buffer while the reader stalls, then drain in order.
    task automatic t_fill();
        bit ok;
        int cnt;
        cnt = 0;
        ok = 1'h1;
        while (ok && cnt < 80) begin
            wr_word(pat(cnt), 200, ok);
            if (ok) cnt++;
        end
        wr_valid = 1'h0;
        check(32'(cnt), 32'(FIFO_DEPTH + BUF_DEPTH));
        check(32'(fifo_full), 32'h1);
        check(32'(wr_ready), 32'h0);
        for (int i = 0; i < cnt; i++) rd_word(pat(i));
        rd_ready = 1'h0;
        repeat (130) @(negedge ref_clk);
        check(32'({fifo_empty, fifo_full, rd_valid}), 32'h4);
    endtask : t_fill

    // Clear with words waiting; the local buffer keeps its two words.
    task automatic t_clear();
        bit ok;
        int n;
        for (int i = 0; i < 3; i++) wr_word(pat(200 + i), 200, ok);
        wr_valid = 1'h0;
        repeat (20) @(negedge ref_clk);
        clr_req = 1'h1;
        @(negedge ref_clk);
        clr_req = 1'h0;
        for (n = 0; n < 4 && fifo_clear_n !== 1'h0; n++) @(negedge ref_clk);
        check(32'(fifo_clear_n), 32'h0);
        repeat (130) @(negedge ref_clk);
        check(32'({fifo_empty, output_valid, wr_ready}), 32'h5);
        rd_word(pat(200));
        rd_word(pat(201));
        rd_ready = 1'h0;
        repeat (10) @(negedge ref_clk);
        check(32'(rd_valid), 32'h0);
    endtask : t_clear

    // Slow fall-through: words still arrive, in order, and not early.
    task automatic t_slow();
        bit ok;
        int n;
        slow = 1'h1;
        for (int i = 0; i < 3; i++) wr_word(pat(300 + i), 200, ok);
        wr_valid = 1'h0;
        for (n = 0; n < 200 && rd_valid !== 1'h1; n++) @(negedge ref_clk);
        check(32'(n > 20 && n < 120), 32'h1);
        check(32'(fifo_empty), 32'h0);
        for (int i = 0; i < 3; i++) rd_word(pat(300 + i));
        rd_ready = 1'h0;
    endtask : t_slow

    // Main sequence: every input valued at time zero, reset for 3 cycles.
    initial begin
        rst_n = 1'h0;
        clr_req = 1'h0;
        wr_valid = 1'h0;
        wr_data = 5'h00;
        rd_ready = 1'h0;
        slow = 1'h0;
        err_total = 0;
        comparisons = 0;
        ld_gap = 1000;
        ul_gap = 1000;
        ld_seen = 1'h0;
        ul_seen = 1'h0;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_stream();
        t_fill();
        t_clear();
        t_slow();
        stop_test();
    end

    // The tests need about 1,700 cycles; a hang is cut off well beyond.
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        stop_test();
    end
endmodule : aftf_host_tb
